// ### logic/adc_core_calibration_ctrl.sv
// calibration control register and status for two dedicated converter cores
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module adc_core_calibration_ctrl (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [cal_ctrl_pkg::ADDR_W-1:0] i_addr,
  input wire logic [cal_ctrl_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [cal_ctrl_pkg::DATA_W-1:0] o_rdata,
  output logic [1:0] o_cal_busy,
  output logic [1:0] o_cal_diff_mode,
  output logic o_irq
);
  typedef struct packed {
    logic [1:0] done;
    logic [1:0] bypass;
    logic [1:0] diff;
    logic [1:0] enable;
    logic [1:0] start;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [cal_ctrl_pkg::DATA_W-1:0] rdata;
  } regs_t;
  regs_t s_q;
  regs_t s_d;

  logic [1:0] pu_start;
  logic [1:0] eng_start;
  logic [1:0] eng_finish;
  logic [1:0] eng_busy;
  logic wr_ctrl;
  logic wr_clr;
  logic wr_mask;
  logic [cal_ctrl_pkg::DATA_W-1:0] ctrl_view;

  assign wr_ctrl = i_wr && (i_addr == cal_ctrl_pkg::CAL_CTRL_ADDR);
  assign wr_clr = i_wr && (i_addr == cal_ctrl_pkg::IRQ_STATUS_ADDR);
  assign wr_mask = i_wr && (i_addr == cal_ctrl_pkg::IRQ_MASK_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // per core engines and power-up requests

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_core
      power_up_start u_pu (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_bypass(s_q.bypass[g]),
        .o_start(pu_start[g])
      );
      // engine takes a start only when idle; the start bit stays set until then
      assign eng_start[g] = (s_q.start[g] || pu_start[g]) && !eng_busy[g];
      cal_engine u_eng (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_start(eng_start[g]),
        .i_diff(s_q.diff[g]),
        .o_busy(eng_busy[g]),
        .o_finish(eng_finish[g]),
        .o_diff_mode(o_cal_diff_mode[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // register view: disabled cores show zero, unused bits read zero

  always_comb begin
    int c;
    c = 0;
    ctrl_view = cal_ctrl_pkg::ZERO16;
    for (c = 0; c < 2; c++) begin
      if (s_q.enable[c]) begin
        ctrl_view[c*cal_ctrl_pkg::CORE_LANE_W + cal_ctrl_pkg::DONE_BIT] =
          s_q.done[c];
        ctrl_view[c*cal_ctrl_pkg::CORE_LANE_W + cal_ctrl_pkg::BYPASS_BIT] =
          s_q.bypass[c];
        ctrl_view[c*cal_ctrl_pkg::CORE_LANE_W + cal_ctrl_pkg::DIFF_BIT] =
          s_q.diff[c];
        ctrl_view[c*cal_ctrl_pkg::CORE_LANE_W + cal_ctrl_pkg::START_BIT] =
          s_q.start[c];
      end
      ctrl_view[c*cal_ctrl_pkg::CORE_LANE_W + cal_ctrl_pkg::ENABLE_BIT] =
        s_q.enable[c];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    int c;
    logic en_new;
    c = 0;
    en_new = 1'b0;
    s_d = s_q;
    s_d.rdata = cal_ctrl_pkg::ZERO16;
    for (c = 0; c < 2; c++) begin
      // start clears once the engine has taken it
      if (eng_start[c]) begin
        s_d.start[c] = 1'b0;
        s_d.done[c] = 1'b0;
      end
      if (eng_finish[c]) begin
        s_d.done[c] = 1'b1;
      end
      if (wr_ctrl) begin
        en_new = i_wdata[c*cal_ctrl_pkg::CORE_LANE_W
                         + cal_ctrl_pkg::ENABLE_BIT];
        s_d.enable[c] = en_new;
        // writes to the gated bits land only while access is enabled
        if (s_q.enable[c]) begin
          s_d.bypass[c] = i_wdata[c*cal_ctrl_pkg::CORE_LANE_W
                                  + cal_ctrl_pkg::BYPASS_BIT];
          s_d.diff[c] = i_wdata[c*cal_ctrl_pkg::CORE_LANE_W
                                + cal_ctrl_pkg::DIFF_BIT];
          // writing zero never aborts a pending start
          if (i_wdata[c*cal_ctrl_pkg::CORE_LANE_W
                      + cal_ctrl_pkg::START_BIT]) begin
            s_d.start[c] = 1'b1;
          end
        end
      end
      // events set sticky status; a set wins over a same-cycle clear
      if (wr_clr && i_wdata[c]) begin
        s_d.irq_status[c] = 1'b0;
      end
      if (eng_finish[c]) begin
        s_d.irq_status[c] = 1'b1;
      end
    end
    if (wr_mask) begin
      s_d.irq_mask = i_wdata[1:0];
    end
    if (i_rd) begin
      case (i_addr)
        cal_ctrl_pkg::CAL_CTRL_ADDR: s_d.rdata = ctrl_view;
        cal_ctrl_pkg::IRQ_STATUS_ADDR:
          s_d.rdata = {14'h0000, s_q.irq_status};
        cal_ctrl_pkg::IRQ_MASK_ADDR:
          s_d.rdata = {14'h0000, s_q.irq_mask};
        default: s_d.rdata = cal_ctrl_pkg::ZERO16;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;
  assign o_cal_busy = eng_busy;
  assign o_irq = |(s_q.irq_status & s_q.irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_DONE_SET: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    eng_finish[0] |=> s_q.done[0])
    else $error("done flag not set on completion");
  AST_DONE_LOW_BUSY: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(eng_busy[1]) |-> !s_q.done[1])
    else $error("done flag high during calibration");
  AST_START_SELF_CLEAR: assert property (@(posedge i_clock)
    disable iff (!i_rst_n)
    eng_start[0] |=> !s_q.start[0] || eng_busy[0])
    else $error("start bit not cleared");
  AST_START_BEGINS: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (s_q.start[0] && !eng_busy[0]) |=> eng_busy[0] ##18 s_q.done[0])
    else $error("start did not run one cycle");
  AST_GATED_WRITE: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (wr_ctrl && !s_q.enable[0]) |=> s_q.bypass[0] == $past(s_q.bypass[0]))
    else $error("write landed while access disabled");
  AST_GATED_READ: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_rd && i_addr == cal_ctrl_pkg::CAL_CTRL_ADDR && !s_q.enable[1])
      |=> o_rdata[15:8] == (8'h02 & {6'h00, $past(s_q.enable[1]), 1'b0}))
    else $error("disabled core bits visible");
  AST_UNUSED_ZERO: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $past(i_rd) |-> (o_rdata[14:12] == 3'h0 && o_rdata[6:4] == 3'h0))
    else $error("unused bits read nonzero");
  AST_IRQ_LEVEL: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (eng_finish[0] && s_q.irq_mask[0]) |=> o_irq)
    else $error("interrupt missing");
  AST_RESET_CLEAR: assert property (@(posedge i_clock)
    $rose(i_rst_n) |-> (s_q.done == 2'h0 && s_q.start == 2'h0
      && s_q.enable == 2'h0))
    else $error("state not cleared by reset");
endmodule
`default_nettype wire

// ### logic/cal_ctrl_pkg.sv
// constants for the converter core calibration control block
//
// Contract
// - done flag reads 1 when core calibration finished, 0 while in progress; the code keeps it at 1 through a run whose start is taken in the finish cycle.
// - bypass bit set skips calibration after power-up; clear calibrates after power-up. Reset clears bypass, so power-up always calibrates.
// - differential select chooses differential (1) or single-ended (0) calibration.
// - access enable gates software access to done, bypass, differential, start bits.
// - writing 1 to start begins one cycle; hardware clears it afterwards.
// - bits 14..12 and 6..4 read zero and ignore writes.
// - reset clears done flags and all writable control bits.
package cal_ctrl_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] CAL_CTRL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 4'h1;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 4'h2;
  // field positions inside one core's byte
  localparam int START_BIT = 0;
  localparam int ENABLE_BIT = 1;
  localparam int DIFF_BIT = 2;
  localparam int BYPASS_BIT = 3;
  localparam int DONE_BIT = 7;
  localparam int CORE_LANE_W = 8;
  localparam logic [7:0] WRITE_MASK = 8'h0f;
  localparam int CAL_CYCLES = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [DATA_W-1:0] ZERO16 = 16'h0000;
  localparam logic [1:0] IRQ_ZERO = 2'h0;
  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_RUN = 2'b01,
    ENG_DONE = 2'b10
  } eng_state_t;
endpackage

// ### logic/cal_engine.sv
// calibration engine model driving one converter core
`timescale 1ns/1ps
`default_nettype none
module cal_engine (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic i_diff,
  output logic o_busy,
  output logic o_finish,
  output logic o_diff_mode
);
  typedef struct packed {
    cal_ctrl_pkg::eng_state_t st;
    logic [cal_ctrl_pkg::CNT_W-1:0] cnt;
    logic diff;
    logic fin;
  } eng_t;
  eng_t s_q;
  eng_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.fin = 1'b0;
    case (s_q.st)
      cal_ctrl_pkg::ENG_IDLE: begin
        if (i_start) begin
          s_d.st = cal_ctrl_pkg::ENG_RUN;
          s_d.cnt = cal_ctrl_pkg::CNT_W'(cal_ctrl_pkg::CAL_CYCLES);
          s_d.diff = i_diff;
        end
      end
      cal_ctrl_pkg::ENG_RUN: begin
        s_d.cnt = s_q.cnt - cal_ctrl_pkg::CNT_ONE;
        if (s_q.cnt == cal_ctrl_pkg::CNT_ONE) begin
          s_d.st = cal_ctrl_pkg::ENG_DONE;
        end
      end
      cal_ctrl_pkg::ENG_DONE: begin
        s_d.fin = 1'b1;
        s_d.st = cal_ctrl_pkg::ENG_IDLE;
      end
      default: s_d.st = cal_ctrl_pkg::ENG_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_busy = (s_q.st != cal_ctrl_pkg::ENG_IDLE);
  assign o_finish = s_q.fin;
  assign o_diff_mode = s_q.diff;

  AST_RUN_LENGTH: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (s_q.st == cal_ctrl_pkg::ENG_IDLE && i_start) |-> ##18 s_q.fin)
    else $error("calibration length wrong");
  AST_DIFF_HELD: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (s_q.st == cal_ctrl_pkg::ENG_IDLE && i_start) |=> o_diff_mode == $past(i_diff))
    else $error("differential mode not captured");
endmodule
`default_nettype wire

// ### logic/power_up_start.sv
// one-shot start request issued once after reset release
`timescale 1ns/1ps
`default_nettype none
module power_up_start (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_bypass,
  output logic o_start
);
  typedef struct packed {
    logic seen;
    logic pulse;
  } pu_t;
  pu_t s_q;
  pu_t s_d;
  always_comb begin
    s_d = s_q;
    s_d.pulse = 1'b0;
    if (!s_q.seen) begin
      s_d.seen = 1'b1;
      s_d.pulse = !i_bypass;
    end
  end
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign o_start = s_q.pulse;
  AST_BYPASS_NO_START: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    ($rose(s_q.seen) && $past(i_bypass)) |-> !o_start)
    else $error("power-up calibration despite bypass");
endmodule
`default_nettype wire

// ### tb/adc_core_calibration_ctrl_tb.sv
// testbench for the converter core calibration control block
`timescale 1ns/1ps
`default_nettype none
module adc_core_calibration_ctrl_tb;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] o_rdata;
  logic [1:0] o_cal_busy;
  logic [1:0] o_cal_diff_mode;
  logic o_irq;
  logic [7:0] len2;
  int errors = 0;
  int n_checks = 0;
  adc_core_calibration_ctrl dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_cal_busy(o_cal_busy),
    .o_cal_diff_mode(o_cal_diff_mode), .o_irq(o_irq));
  cal_run_watch far2 (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_busy(o_cal_busy[0]), .o_len(len2));
  initial begin
    forever #50 i_clock = ~i_clock;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, logic [15:0] exp, string nm);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    chk(nm, exp, o_rdata);
  endtask
  // bounded wait on the engines' busy pair
  task automatic wait_busy(logic [1:0] v);
    int k;
    for (k = 0; k < 60 && o_cal_busy !== v; k++) begin
      @(posedge i_clock);
      #1;
    end
    chk("busy", {14'h0000, v}, {14'h0000, o_cal_busy});
  endtask
  task automatic print_verdict();
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_power_up();
    wait_busy(2'b11);
    rd(4'h0, 16'h0000, "ctrl_locked");
    wait_busy(2'b00);
    // the watcher latches the run length one edge after busy falls
    @(posedge i_clock);
    #1;
    // busy spans the run cycles plus the one completion cycle
    chk("run_len", 16'(cal_ctrl_pkg::CAL_CYCLES + 1), {8'h00, len2});
    wr(4'h0, 16'h0202);
    rd(4'h0, 16'h8282, "ctrl_done");
  endtask
  task automatic t_irq();
    #1;
    chk("irq_masked", 16'h0000, {15'h0000, o_irq});
    wr(4'h2, 16'h0003);
    #1;
    chk("irq_on", 16'h0001, {15'h0000, o_irq});
    wr(4'h1, 16'h0001);
    rd(4'h1, 16'h0002, "status");
    wr(4'h1, 16'h0002);
    #1;
    chk("irq_off", 16'h0000, {15'h0000, o_irq});
    rd(4'h3, 16'h0000, "unmapped");
  endtask
  task automatic t_start_diff();
    wr(4'h0, 16'h0206);
    wr(4'h0, 16'h0207);
    wait_busy(2'b01);
    rd(4'h0, 16'h8206, "ctrl_running");
    wait_busy(2'b00);
    rd(4'h0, 16'h8286, "ctrl_after");
    chk("diff_mode", 16'h0001, {14'h0000, o_cal_diff_mode});
    chk("run_len2", 16'(cal_ctrl_pkg::CAL_CYCLES + 1), {8'h00, len2});
  endtask
  task automatic t_reserved_and_gate();
    wr(4'h0, 16'h7272);
    rd(4'h0, 16'h8282, "ctrl_reserved");
    wr(4'h0, 16'h0000);
    wr(4'h0, 16'h0d0d);
    rd(4'h0, 16'h0000, "ctrl_gated");
    repeat (4) @(posedge i_clock);
    #1;
    chk("no_start", 16'h0000, {14'h0000, o_cal_busy});
    wr(4'h0, 16'h0202);
    rd(4'h0, 16'h8282, "ctrl_kept");
  endtask
  task automatic t_second_reset();
    wr(4'h0, 16'h0a0a);
    @(posedge i_clock);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'b1;
    wait_busy(2'b11);
    wait_busy(2'b00);
    rd(4'h0, 16'h0000, "ctrl_reset");
    rd(4'h2, 16'h0000, "mask_reset");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_power_up();
    t_irq();
    t_start_diff();
    t_reserved_and_gate();
    t_second_reset();
    print_verdict();
  end
  initial begin
    #500000;
    errors++;
    print_verdict();
  end
endmodule
`default_nettype wire

// ### tb/cal_run_watch.sv
// far-side model: times each calibration run of one core engine
`timescale 1ns/1ps
`default_nettype none
module cal_run_watch (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_busy,
  output logic [7:0] o_len
);
  logic [7:0] cnt_q;
  // an engine run is one unbroken busy stretch; its length is kept
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 8'h00;
      o_len <= 8'h00;
    end else if (i_busy) begin
      cnt_q <= cnt_q + 8'h01;
    end else if (cnt_q != 8'h00) begin
      o_len <= cnt_q;
      cnt_q <= 8'h00;
    end
  end
endmodule
`default_nettype wire
